/* File: sim/lsfc_checker.sv */
`include "lsfc_consts.svh"
module lsfc_checker
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Memory and driver pins
  input wire logic        busReq,
  input wire logic        busGrant,
  input wire logic        memRd,
  input wire logic [7:0]  dataOut,
  input wire logic        shiftClockOut,
  input wire logic        latchPulseOut,
  input wire logic        origCs_n,
  input wire logic        wrStrobe_n,
  input wire logic        driverCs_n,
  input wire logic        displayOffOut_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Completed write to the control register
  wire logic ctlWr;
  assign ctlWr = psel && penable && pready && pwrite && paddr[1:0] == 2'h0
                 && paddr[13:2] == `LSFC_IDX_CONTROL;

  // Exactly one wait state, answer lasts one cycle
  AST_PREADY_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // Reads only while the bus is owned
  AST_READ_OWNED: assert property (memRd |-> busReq && $past(busReq) && $past(busGrant))
    else $error("memory read without granted bus");
  AST_SHIFT_OWNED: assert property (shiftClockOut |-> busReq)
    else $error("shift clock running after bus request dropped");
  // Data must not move at the capture edge
  AST_SHIFT_STABLE: assert property ($fell(shiftClockOut) |-> $stable(dataOut))
    else $error("data changed at falling shift clock");
  // Past reset guard avoids the flop still holding its reset value
  AST_CS_MERGE: assert property ($past(rst_n) |-> driverCs_n == ($past(origCs_n) | $past(wrStrobe_n)))
    else $error("driver select is not select OR write strobe");
  AST_LATCH_WIDTH: assert property ($rose(latchPulseOut) |-> latchPulseOut[*4] ##1 !latchPulseOut)
    else $error("latch pulse width not four cycles");
  AST_DISPLAY_BIT: assert property (ctlWr |-> ##2 displayOffOut_n == $past(pwdata[7], 2))
    else $error("display off output does not follow control bit 7");

  // Main scenarios reached
  cover property (ctlWr);
  cover property (memRd);
  cover property ($rose(latchPulseOut));
endmodule

bind lsfc_top lsfc_checker chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .busReq, .busGrant, .memRd, .dataOut, .shiftClockOut, .latchPulseOut, .origCs_n,
  .wrStrobe_n, .driverCs_n, .displayOffOut_n);

/* File: sim/lsfc_drv_model.sv */
`include "lsfc_consts.svh"
module lsfc_drv_model
(
  // Clock, reset, mode
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire lsfc_pkg::lsfc_width_t width,
  // System bus and memory
  input  wire logic                  busReq,
  output logic                       busGrant,
  input  wire logic [23:0]           memAddr,
  input  wire logic                  memRd,
  output logic      [7:0]            memData,
  output logic                       memValid,
  // Column and row drivers
  input  wire logic [7:0]            dataOut,
  input  wire logic                  shiftClockOut,
  input  wire logic                  latchPulseOut,
  output int                         nBytes,
  output int                         nLines,
  output logic      [7:0]            lastByte
);
  timeunit 1ns;
  timeprecision 1ps;
  import lsfc_pkg::*;
  int         seed = 62599;
  int         waitCnt;
  int         nBits;
  int         step;
  logic       pend;
  logic [7:0] held;
  logic [7:0] shReg;

  // Grant after a random delay, kept while requested; memory answers late
  always @(posedge clk_sys)
  begin
    busGrant <= rst_n && busReq && (busGrant || $random(seed) % 3 == 0);
    memValid <= 1'b0;
    // Released data lines show the inverse of the last value
    memData <= ~memData;
    if (!rst_n)
    begin
      pend    <= 1'b0;
      memData <= 8'h3C;
    end
    else if (memRd)
    begin
      pend    <= 1'b1;
      waitCnt <= $unsigned($random(seed)) % 4;
      held    <= memAddr[7:0] ^ 8'hA5;
    end
    else if (pend && waitCnt == 0)
    begin
      pend     <= 1'b0;
      memValid <= 1'b1;
      memData  <= held;
    end
    else if (pend)
      waitCnt <= waitCnt - 1;
  end

  // Column driver samples on falling shift clock
  always @(negedge shiftClockOut or negedge rst_n)
  begin
    step = (width == `LSFC_WIDTH_BYTE) ? 8 : (width == `LSFC_WIDTH_NIBBLE) ? 4 : 1;
    if (!rst_n)
      nBits = 0;
    else
    begin
      shReg = (shReg << step) | (dataOut & 8'((1 << step) - 1));
      nBits = nBits + step;
      if (nBits == 8)
      begin
        nBits    = 0;
        lastByte = shReg;
        nBytes   = nBytes + 1;
      end
    end
  end

  // A line is taken on the rising latch pulse
  always @(posedge latchPulseOut)
    nLines = nLines + 1;
endmodule

/* File: sim/lsfc_top_tb.sv */
`include "lsfc_consts.svh"
module lsfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lsfc_pkg::*;
  localparam int FRAME_BYTES = 256; // 32 segments, 64 commons
  logic        clk_sys = 0, rst_n = 0, oscClkIn = 0, timerPulseIn = 0;
  logic        psel = 0, penable = 0, pwrite = 0, origCs_n = 1, wrStrobe_n = 1;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdData;
  logic        pready, pslverr, rdErr, busReq, busGrant, memRd, memValid, driverCs_n;
  logic [23:0] memAddr, expStart;
  logic [7:0]  memData, dataOut, lastByte, expByte, v;
  logic        shiftClockOut, latchPulseOut, framePolarityOut, cascadePulseOut;
  logic        displayOffOut_n, cascPrev, latchPrev, csRun = 0;
  lsfc_width_t width = `LSFC_WIDTH_BYTE;
  int          seed = 62599, failures = 0, n_checks = 0;
  int          nRd, seen, nBytes, nLines, nCasc = 0, cyc = 0, lpLast, lpGap;

  // Clocks: system, oscillator and timer output, unrelated in phase
  initial forever #2 clk_sys = ~clk_sys;
  initial #1 forever #24 oscClkIn = ~oscClkIn;
  initial #3 forever #40 timerPulseIn = ~timerPulseIn;

  lsfc_top uut (.clk_sys, .rst_n, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .oscClkIn, .timerPulseIn, .busReq, .busGrant, .memAddr, .memRd,
    .memData, .memValid, .origCs_n, .wrStrobe_n, .driverCs_n, .dataOut, .shiftClockOut,
    .latchPulseOut, .framePolarityOut, .cascadePulseOut, .displayOffOut_n);
  lsfc_drv_model drv (.clk_sys, .rst_n, .width, .busReq, .busGrant, .memAddr, .memRd, .memData,
    .memValid, .dataOut, .shiftClockOut, .latchPulseOut, .nBytes, .nLines, .lastByte);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; one idle edge after release keeps drives apart
  task automatic apb(input logic wrEn, input logic [11:0] idx, input logic [1:0] sub,
                     input logic [7:0] wd);
    int k;
    psel    <= 1'b1;
    pwrite  <= wrEn;
    paddr   <= {idx, sub};
    pwdata  <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rdData = prdata;
    rdErr  = pslverr;
    if (k >= 50)
      check("apb answer", 1, pready);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 2'h0, d);
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  // Random select traffic; cascade and latch edges; read and byte stream
  always @(posedge clk_sys)
  begin
    origCs_n   <= !csRun || $random(seed) % 2 == 0;
    wrStrobe_n <= !csRun || $random(seed) % 2 == 0;
    cyc++;
    if (cascadePulseOut && !cascPrev)
    begin
      nCasc++;
      // Frame start rewinds the read address
      nRd = 0;
    end
    if (latchPulseOut && !latchPrev)
    begin
      lpGap  = cyc - lpLast;
      lpLast = cyc;
    end
    cascPrev  = cascadePulseOut;
    latchPrev = latchPulseOut;
    if (nBytes != seen)
    begin
      check("driver byte", expByte, lastByte);
      seen = nBytes;
    end
    if (rst_n === 1'b1 && memRd === 1'b1)
    begin
      check("read address", expStart + 24'(nRd % FRAME_BYTES), memAddr);
      expByte = 8'(expStart + 24'(nRd % FRAME_BYTES)) ^ 8'hA5;
      nRd++;
    end
  end

  // Wait for a frame edge, then pass the cascade count, before any byte of line 0
  task automatic wait_frame();
    logic fp;
    int   k;
    fp = framePolarityOut;
    k = 0;
    while (framePolarityOut === fp && k < 50000)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (2) @(posedge clk_sys);
    check("frame polarity", !fp, framePolarityOut);
  endtask

  task automatic run_mode(input lsfc_width_t w, input logic sel, input logic [8:0] fset,
                          input int gap);
    int l0;
    int b0;
    int c0;
    reset_dut();
    width = w;
    expStart = 24'($random(seed)) & 24'hFFF000;
    nRd = 0;
    seen = nBytes;
    // Source, size and timing go in before the start bit
    wr(`LSFC_IDX_START_LOW, {expStart[15:12], 4'h1});
    wr(`LSFC_IDX_START_HIGH, expStart[23:16]);
    wr(`LSFC_IDX_PANEL_SIZE, 8'h00);
    wr(`LSFC_IDX_FRAME_LOW, fset[7:0]);
    wr(`LSFC_IDX_CLK_SELECT, {7'h0, sel});
    wr(`LSFC_IDX_CONTROL, {3'h4, w, 1'b0, fset[8], 1'b1});
    wait_frame();
    l0 = nLines;
    b0 = nBytes;
    c0 = nCasc;
    wait_frame();
    check("lines per frame", fset, nLines - l0);
    check("cascade pulses", 1, nCasc - c0);
    check("bytes per frame", FRAME_BYTES, nBytes - b0);
    check("latch period", gap, lpGap);
    wr(`LSFC_IDX_CONTROL, 8'h80);
    repeat (200) @(posedge clk_sys);
    l0 = nRd;
    repeat (300) @(posedge clk_sys);
    check("reads after stop", l0, nRd);
    check("bus request after stop", 0, busReq);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cut a hang short; the run needs about 82k cycles
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end

  initial
  begin
    reset_dut();
    for (int i = 'h360; i <= 'h365; i++)
    begin
      apb(1'b0, 12'(i), 2'h0, 8'h00);
      check("reset value", 0, rdData);
    end
    apb(1'b0, 12'h367, 2'h0, 8'h00);
    check("unmapped error", 1, rdErr);
    check("unmapped data", 0, rdData);
    apb(1'b0, `LSFC_IDX_CONTROL, 2'h2, 8'h00);
    check("misaligned error", 1, rdErr);
    csRun = 1;
    // Random control and frame values, start bit kept low
    repeat (8)
    begin
      v = $random(seed) & 8'h9E;
      wr(`LSFC_IDX_CONTROL, v);
      apb(1'b0, `LSFC_IDX_CONTROL, 2'h0, 8'h00);
      check("control readback", {24'h0, v}, rdData);
      check("display off pin", v[7], displayOffOut_n);
      v = $random(seed);
      wr(`LSFC_IDX_FRAME_LOW, v);
      apb(1'b0, `LSFC_IDX_FRAME_LOW, 2'h0, 8'h00);
      check("frame low readback", {24'h0, v}, rdData);
    end
    run_mode(`LSFC_WIDTH_BYTE, 1'b0, 9'(64 + $unsigned($random(seed)) % 8), 78);
    run_mode(`LSFC_WIDTH_NIBBLE, 1'b0, 9'(64 + $unsigned($random(seed)) % 8), 78);
    // Bit mode only with 64 commons here
    run_mode(`LSFC_WIDTH_BIT, 1'b1, 9'(64 + $unsigned($random(seed)) % 8), 130);
    run_mode(`LSFC_WIDTH_BYTE, 1'b0, 9'(256 + $unsigned($random(seed)) % 4), 78);
    print_verdict();
  end
endmodule

/* File: verilog/lsfc_consts.svh */
`ifndef LSFC_CONSTS_SVH
`define LSFC_CONSTS_SVH

// Register indices and register reset value; byte address is four times the index
`define LSFC_IDX_START_LOW   12'h360
`define LSFC_IDX_START_HIGH  12'h361
`define LSFC_IDX_PANEL_SIZE  12'h362
`define LSFC_IDX_CONTROL     12'h363
`define LSFC_IDX_FRAME_LOW   12'h364
`define LSFC_IDX_CLK_SELECT  12'h365
`define LSFC_IDX_STATUS      12'h366
`define LSFC_REG_RESET       8'h00
// Control register fields, and the mode bit of the start low register
`define LSFC_CTL_DISPLAY_ON  7
`define LSFC_CTL_WIDTH_HI    4
`define LSFC_CTL_WIDTH_LO    3
`define LSFC_CTL_DIRECT_RAM  2
`define LSFC_CTL_FRAME_MSB   1
`define LSFC_CTL_START       0
`define LSFC_SAL_MODE        0
// Width encodings
`define LSFC_WIDTH_BYTE      2'h0
`define LSFC_WIDTH_NIBBLE    2'h1
`define LSFC_WIDTH_BIT       2'h2
// Shift slot lengths in system clocks (byte 4, nibble 2x3, bit 8x2 plus 2)
`define LSFC_SLOT_BYTE       5'h04
`define LSFC_SLOT_NIBBLE     5'h03
`define LSFC_SLOT_BIT        5'h02
// Latch pulse width in system clocks
`define LSFC_LATCH_WIDTH     4'h4
`endif

/* File: verilog/lsfc_pkg.sv */
package lsfc_pkg;
  typedef enum logic [2:0] {XF_IDLE, XF_REQ, XF_READ, XF_SHIFT, XF_DONE} lsfc_xfer_t;
  typedef logic [1:0] lsfc_width_t;
endpackage

/* File: verilog/lsfc_top.sv */
`include "lsfc_consts.svh"
module lsfc_top
(
  // Clock, reset, enable
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clkEn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [13:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Panel source clock candidates (pins)
  input  wire logic                 oscClkIn,
  input  wire logic                 timerPulseIn,
  // System bus master
  output logic                      busReq,
  input  wire logic                 busGrant,
  output logic      [23:0]          memAddr,
  output logic                      memRd,
  input  wire logic [7:0]           memData,
  input  wire logic                 memValid,
  // Driver chip select path
  input  wire logic                 origCs_n,
  input  wire logic                 wrStrobe_n,
  output logic                      driverCs_n,
  // Driver pins
  output logic      [7:0]           dataOut,
  output logic                      shiftClockOut,
  output logic                      latchPulseOut,
  output logic                      framePolarityOut,
  output logic                      cascadePulseOut,
  output logic                      displayOffOut_n
);
  import lsfc_pkg::*;

  // Half-cycles of the source clock per line, i.e. 2*D
  function automatic logic [3:0] halfEdges(input logic [3:0] com);
    case (com)
      4'h0: halfEdges = 4'hD;
      4'h1: halfEdges = 4'hC;
      4'h2: halfEdges = 4'hA;
      4'h3: halfEdges = 4'h8;
      4'h4: halfEdges = 4'h7;
      4'h5: halfEdges = 4'h6;
      4'h6: halfEdges = 4'h5;
      4'h7: halfEdges = 4'h5;
      4'h8: halfEdges = 4'h4;
      default: halfEdges = 4'h3;
    endcase
  endfunction

  function automatic logic [8:0] comLines(input logic [3:0] com);
    case (com)
      4'h0: comLines = 9'h040;
      4'h1: comLines = 9'h044;
      4'h2: comLines = 9'h050;
      4'h3: comLines = 9'h064;
      4'h4: comLines = 9'h078;
      4'h5: comLines = 9'h080;
      4'h6: comLines = 9'h090;
      4'h7: comLines = 9'h0A0;
      4'h8: comLines = 9'h0C8;
      default: comLines = 9'h0F0;
    endcase
  endfunction

  // Bytes per line: segments / 8
  function automatic logic [5:0] segBytes(input logic [3:0] seg);
    case (seg)
      4'h0: segBytes = 6'h04;
      4'h1: segBytes = 6'h08;
      4'h2: segBytes = 6'h0A;
      4'h3: segBytes = 6'h0F;
      4'h4: segBytes = 6'h10;
      4'h5: segBytes = 6'h14;
      4'h6: segBytes = 6'h1E;
      4'h7: segBytes = 6'h28;
      default: segBytes = 6'h2D;
    endcase
  endfunction

  // Register group
  logic [7:0]  startLow_r, startHigh_r, size_r, ctl_r, frameLow_r;
  logic        clkSel_r;
  logic [7:0]  startLow_nxt, startHigh_nxt, size_nxt, ctl_nxt, frameLow_nxt;
  logic        clkSel_nxt, pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [11:0] regIdx;
  logic        hit, wrTake;
  logic        busy;

  assign regIdx = paddr[13:2];
  assign wrTake = psel & penable & pready & pwrite & ~pslverr;
  assign hit    = (regIdx >= `LSFC_IDX_START_LOW) && (regIdx <= `LSFC_IDX_STATUS)
                  && (paddr[1:0] == 2'h0);

  // One wait state: answer in the second access cycle
  always_comb
  begin
    startLow_nxt  = startLow_r;
    startHigh_nxt = startHigh_r;
    size_nxt      = size_r;
    ctl_nxt       = ctl_r;
    frameLow_nxt  = frameLow_r;
    clkSel_nxt    = clkSel_r;
    pready_nxt    = psel & penable & ~pready;
    pslverr_nxt   = psel & penable & ~pready & ~hit;
    prdata_nxt    = 32'h0000_0000;
    if (psel && penable && !pready && !pwrite)
    begin
      case (regIdx)
        `LSFC_IDX_START_LOW:  prdata_nxt = {24'h000000, startLow_r};
        `LSFC_IDX_START_HIGH: prdata_nxt = {24'h000000, startHigh_r};
        `LSFC_IDX_PANEL_SIZE: prdata_nxt = {24'h000000, size_r};
        `LSFC_IDX_CONTROL:    prdata_nxt = {24'h000000, ctl_r};
        `LSFC_IDX_FRAME_LOW:  prdata_nxt = {24'h000000, frameLow_r};
        `LSFC_IDX_CLK_SELECT: prdata_nxt = {31'h00000000, clkSel_r};
        `LSFC_IDX_STATUS:     prdata_nxt = {30'h00000000, framePolarityOut, busy};
        default:              prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wrTake)
    begin
      case (regIdx)
        `LSFC_IDX_START_LOW:  startLow_nxt  = pwdata[7:0];
        `LSFC_IDX_START_HIGH: startHigh_nxt = pwdata[7:0];
        `LSFC_IDX_PANEL_SIZE: size_nxt      = pwdata[7:0];
        `LSFC_IDX_CONTROL:    ctl_nxt       = pwdata[7:0];
        `LSFC_IDX_FRAME_LOW:  frameLow_nxt  = pwdata[7:0];
        `LSFC_IDX_CLK_SELECT: clkSel_nxt    = pwdata[0];
        default:              clkSel_nxt    = clkSel_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      startLow_r  <= `LSFC_REG_RESET;
      startHigh_r <= `LSFC_REG_RESET;
      size_r      <= `LSFC_REG_RESET;
      ctl_r       <= `LSFC_REG_RESET;
      frameLow_r  <= `LSFC_REG_RESET;
      clkSel_r    <= 1'b0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      startLow_r  <= startLow_nxt;
      startHigh_r <= startHigh_nxt;
      size_r      <= size_nxt;
      ctl_r       <= ctl_nxt;
      frameLow_r  <= frameLow_nxt;
      clkSel_r    <= clkSel_nxt;
      pready      <= pready_nxt;
      pslverr     <= pslverr_nxt;
      prdata      <= prdata_nxt;
    end
  end

  // Decoded configuration
  logic        running;
  lsfc_width_t width;
  logic [8:0]  frameSet, comCount;
  logic [3:0]  lineEdges;
  logic [5:0]  lineBytes;
  assign frameSet  = {ctl_r[`LSFC_CTL_FRAME_MSB], frameLow_r};
  assign running   = ctl_r[`LSFC_CTL_START] & startLow_r[`LSFC_SAL_MODE];
  assign width     = ctl_r[`LSFC_CTL_WIDTH_HI:`LSFC_CTL_WIDTH_LO];
  assign lineEdges = halfEdges(size_r[7:4]);
  assign comCount  = comLines(size_r[7:4]);
  assign lineBytes = segBytes(size_r[3:0]);

  // Two-flop source clock synchronisers; srcLevel_r keeps the last level
  logic [1:0] oscSync_r, tmrSync_r, oscSync_nxt, tmrSync_nxt;
  logic       srcLevel_r, srcLevel_nxt, srcEdge;

  always_comb
  begin
    oscSync_nxt  = {oscSync_r[0], oscClkIn};
    tmrSync_nxt  = {tmrSync_r[0], timerPulseIn};
    // oscillator when 0, timer when 1
    srcLevel_nxt = clkSel_r ? tmrSync_r[1] : oscSync_r[1];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      oscSync_r  <= 2'h0;
      tmrSync_r  <= 2'h0;
      srcLevel_r <= 1'b0;
    end
    else if (clkEn)
    begin
      oscSync_r  <= oscSync_nxt;
      tmrSync_r  <= tmrSync_nxt;
      srcLevel_r <= srcLevel_nxt;
    end
  end

  // Both edges count, so half-integer D needs no extra divider
  assign srcEdge = srcLevel_r ^ (clkSel_r ? tmrSync_r[1] : oscSync_r[1]);

  // Line and frame timing group
  logic [3:0] edgeCnt_r, edgeCnt_nxt, latchCnt_r, latchCnt_nxt;
  logic [8:0] lineCnt_r, lineCnt_nxt;
  logic       frame_r, frame_nxt, cascade_r, cascade_nxt, lineTick;
  logic       dispOn_r, dispOn_nxt, cs_r, cs_nxt;
  logic       latch_r, latch_nxt;

  // line period of 2*D source half-cycles
  assign lineTick = running && srcEdge && (edgeCnt_r == lineEdges - 4'h1);

  always_comb
  begin
    edgeCnt_nxt  = edgeCnt_r;
    lineCnt_nxt  = lineCnt_r;
    frame_nxt    = frame_r;
    latchCnt_nxt = (latchCnt_r != 4'h0) ? latchCnt_r - 4'h1 : 4'h0;
    if (!running)
    begin
      edgeCnt_nxt = 4'h0;
      lineCnt_nxt = 9'h000;
    end
    else if (srcEdge)
      edgeCnt_nxt = lineTick ? 4'h0 : edgeCnt_r + 4'h1;
    if (lineTick)
    begin
      // rising latch edge loads the shifted line
      latchCnt_nxt = `LSFC_LATCH_WIDTH;
      if (lineCnt_r + 9'h001 >= frameSet)
      begin
        lineCnt_nxt = 9'h000;
        frame_nxt   = ~frame_r;
      end
      else
        lineCnt_nxt = lineCnt_r + 9'h001;
    end
    // one cascade pulse, a single cycle as each frame wraps to line 0
    cascade_nxt = running && (lineCnt_nxt == 9'h000) && (lineCnt_r != 9'h000 || lineTick);
    dispOn_nxt  = ctl_r[`LSFC_CTL_DISPLAY_ON];
    cs_nxt      = origCs_n | wrStrobe_n;
    // Latch pin from a flop, high while the count runs
    latch_nxt   = (latchCnt_nxt != 4'h0);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      edgeCnt_r  <= 4'h0;
      lineCnt_r  <= 9'h000;
      frame_r    <= 1'b0;
      latchCnt_r <= 4'h0;
      cascade_r  <= 1'b0;
      dispOn_r   <= 1'b0;
      cs_r       <= 1'b1;
      latch_r    <= 1'b0;
    end
    else if (clkEn)
    begin
      latch_r    <= latch_nxt;
      edgeCnt_r  <= edgeCnt_nxt;
      lineCnt_r  <= lineCnt_nxt;
      frame_r    <= frame_nxt;
      latchCnt_r <= latchCnt_nxt;
      cascade_r  <= cascade_nxt;
      dispOn_r   <= dispOn_nxt;
      cs_r       <= cs_nxt;
    end
  end

  assign framePolarityOut = frame_r;
  assign cascadePulseOut  = cascade_r;
  assign displayOffOut_n  = dispOn_r;
  assign driverCs_n       = cs_r;
  assign latchPulseOut    = latch_r;

  // Transfer group
  lsfc_xfer_t  st_r, st_nxt;
  logic        pend_r, pend_nxt, req_r, req_nxt, rd_r, rd_nxt, scp_r, scp_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [5:0]  byteCnt_r, byteCnt_nxt;
  logic [7:0]  byte_r, byte_nxt, dout_r, dout_nxt;
  logic [4:0]  ph_r, ph_nxt, slotLen;
  logic [3:0]  idx_r, idx_nxt, shifts, slots;

  // slot lengths give 4, 6 and 18 cycles per byte
  always_comb
  begin
    case (width)
      `LSFC_WIDTH_NIBBLE: begin slotLen = `LSFC_SLOT_NIBBLE; shifts = 4'h2; end
      `LSFC_WIDTH_BIT:    begin slotLen = `LSFC_SLOT_BIT;    shifts = 4'h8; end
      default:            begin slotLen = `LSFC_SLOT_BYTE;   shifts = 4'h1; end
    endcase
    slots = (width == `LSFC_WIDTH_BIT) ? 4'h9 : shifts;
  end

  always_comb
  begin
    st_nxt      = st_r;
    req_nxt     = req_r;
    rd_nxt      = 1'b0;
    addr_nxt    = addr_r;
    byteCnt_nxt = byteCnt_r;
    byte_nxt    = byte_r;
    ph_nxt      = ph_r;
    idx_nxt     = idx_r;
    dout_nxt    = dout_r;
    scp_nxt     = 1'b0;
    // Line request; a new tick wins over the clear below
    pend_nxt    = pend_r;
    if (st_r == XF_IDLE && pend_r)
      pend_nxt = 1'b0;
    if (lineTick && lineCnt_nxt < comCount)
      pend_nxt = 1'b1;
    // frame start rewinds to the start address
    if (lineTick && lineCnt_nxt == 9'h000)
      addr_nxt = {startHigh_r, startLow_r[7:4], 12'h000};
    case (st_r)
      XF_IDLE:
        if (pend_r && running)
        begin
          req_nxt     = 1'b1;
          byteCnt_nxt = 6'h00;
          st_nxt      = XF_REQ;
        end
      XF_REQ:
        if (busGrant)
        begin
          rd_nxt = 1'b1;
          st_nxt = XF_READ;
        end
      XF_READ:
        if (memValid)
        begin
          byte_nxt = memData;
          ph_nxt   = 5'h00;
          idx_nxt  = 4'h0;
          st_nxt   = XF_SHIFT;
        end
      XF_SHIFT:
      begin
        // data held across the falling shift edge
        if (idx_r < shifts)
        begin
          scp_nxt = (width == `LSFC_WIDTH_BYTE) ? (ph_r < 5'h02) : (ph_r == 5'h00);
          case (width)
            `LSFC_WIDTH_NIBBLE: dout_nxt = {4'h0, idx_r[0] ? byte_r[3:0] : byte_r[7:4]};
            `LSFC_WIDTH_BIT:    dout_nxt = {7'h00, byte_r[3'h7 - idx_r[2:0]]};
            default:            dout_nxt = byte_r;
          endcase
        end
        ph_nxt = ph_r + 5'h01;
        if (ph_r == slotLen - 5'h01)
        begin
          ph_nxt  = 5'h00;
          idx_nxt = idx_r + 4'h1;
          if (idx_r == slots - 4'h1)
          begin
            addr_nxt    = addr_r + 24'h000001;
            byteCnt_nxt = byteCnt_r + 6'h01;
            // stop after the panel's bytes per line
            if (byteCnt_r == lineBytes - 6'h01)
              st_nxt = XF_DONE;
            else
            begin
              rd_nxt = 1'b1;
              st_nxt = XF_READ;
            end
          end
        end
      end
      XF_DONE:
      begin
        req_nxt = 1'b0;
        st_nxt  = XF_IDLE;
      end
      default: st_nxt = XF_IDLE;
    endcase
    if (!running)
    begin
      st_nxt   = XF_IDLE;
      req_nxt  = 1'b0;
      pend_nxt = 1'b0;
      // A stop must not leave a shift pulse without the bus
      scp_nxt  = 1'b0;
      addr_nxt = {startHigh_r, startLow_r[7:4], 12'h000};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r      <= XF_IDLE;
      pend_r    <= 1'b0;
      req_r     <= 1'b0;
      rd_r      <= 1'b0;
      scp_r     <= 1'b0;
      addr_r    <= 24'h000000;
      byteCnt_r <= 6'h00;
      byte_r    <= 8'h00;
      dout_r    <= 8'h00;
      ph_r      <= 5'h00;
      idx_r     <= 4'h0;
    end
    else if (clkEn)
    begin
      st_r      <= st_nxt;
      pend_r    <= pend_nxt;
      req_r     <= req_nxt;
      rd_r      <= rd_nxt;
      scp_r     <= scp_nxt;
      addr_r    <= addr_nxt;
      byteCnt_r <= byteCnt_nxt;
      byte_r    <= byte_nxt;
      dout_r    <= dout_nxt;
      ph_r      <= ph_nxt;
      idx_r     <= idx_nxt;
    end
  end

  assign busy          = req_r;
  assign busReq        = req_r;
  assign memRd         = rd_r;
  assign memAddr       = addr_r;
  assign dataOut       = dout_r;
  assign shiftClockOut = scp_r;
endmodule
